/* File: verilog/cptc_defs.vh */
`ifndef CPTC_DEFS_VH
`define CPTC_DEFS_VH

// Register numbers carried in the low nibble of the instruction byte
`define CPTC_ADDR_W 4
`define CPTC_ADDR_PCM_CTRL 4'h1
`define CPTC_ADDR_RX_DATA 4'h2
`define CPTC_ADDR_TX_DATA 4'h3
`define CPTC_ADDR_ROUTING 4'h4
`define CPTC_ADDR_TX_ST_GAIN 4'h5
`define CPTC_ADDR_OUT_GAIN 4'h6
`define CPTC_ADDR_TONE_CTRL 4'h7
`define CPTC_ADDR_TONE_PRI 4'h8
`define CPTC_ADDR_TONE_SEC 4'h9
`define CPTC_ADDR_TONE_RANGE 4'ha

// Instruction byte layout
`define CPTC_INS_READ 7
`define CPTC_INS_ADDR_HI 3
`define CPTC_FRAME_BITS 5'h10
`define CPTC_BYTE_BITS 5'h08

// pcm_interface_control bits
`define CPTC_RX_OVR 4
`define CPTC_TX_OVR 3
`define CPTC_VOICE_EN 2
`define CPTC_SLOT_PICK 1

// path_routing_control bits
`define CPTC_MIC_HI 7
`define CPTC_MIC_LO 6
`define CPTC_SIDETONE_EN 5
`define CPTC_EARPIECE_ON 4
`define CPTC_AUX_ON 3
`define CPTC_TONE_ROUTE 2
`define CPTC_SPEECH_STEER 0
`define CPTC_MIC_MUTE 2'h3

// tone_generator_control bits
`define CPTC_PRI_ON 3
`define CPTC_SEC_ON 2
`define CPTC_WAVE 1
`define CPTC_TONE_TX 0

// tone_range_control codes
`define CPTC_RANGE_STD 2'h0
`define CPTC_RANGE_HALF 2'h1
`define CPTC_RANGE_DOUBLE 2'h2

// Reset values
`define CPTC_RST_BYTE 8'h00
// Idle pin levels {cs_b, sclk, sdi, fs, bclk, dr}: clocks parked high, so no false edge after reset
`define CPTC_PIN_IDLE 6'h32

// PCM slot layout
`define CPTC_SLOT_BITS 5'h08
`define CPTC_SLOT1_START 5'h00
`define CPTC_SLOT2_START 5'h08
`define CPTC_SLOT_CNT_MAX 5'h1f

// Tone generator timing and levels
`define CPTC_CLK_HZ 200000000
`define CPTC_TONE_RATE_HZ 8000
`define CPTC_TONE_TICK_CYCLES (`CPTC_CLK_HZ / `CPTC_TONE_RATE_HZ)
`define CPTC_TONE_FULL 11'h3ff
`define CPTC_SEC_SCALE 8'hcb

`endif

/* File: verilog/cptc_buf2.v */
`timescale 1ns/1ps
// Two-entry buffer: output register plus one skid entry
module cptc_buf2 #(
  parameter WIDTH = 8
) (
  input wire clk,
  input wire rst_b,
  input wire in_valid,
  output reg in_ready,
  input wire [WIDTH-1:0] in_data,
  output reg out_valid,
  input wire out_ready,
  output reg [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] skid_data;

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      in_ready <= 1'b1;
      out_valid <= 1'b0;
      out_data <= {WIDTH{1'b0}};
      skid_data <= {WIDTH{1'b0}};
    end
    else if (out_ready || !out_valid)
    begin
      if (!in_ready)
      begin
        out_valid <= 1'b1;
        out_data <= skid_data;
        in_ready <= 1'b1;
      end
      else
      begin
        out_valid <= in_valid;
        out_data <= in_data;
      end
    end
    else if (in_valid && in_ready)
    begin
      // Receiver stalled: park the word, close the input
      skid_data <= in_data;
      in_ready <= 1'b0;
    end
  end
endmodule // cptc_buf2

/* File: verilog/cptc_top.v */
`timescale 1ns/1ps
`include "cptc_defs.vh"
module cptc_top #(
  parameter TONE_TICK_CYCLES = `CPTC_TONE_TICK_CYCLES,
  parameter TONE_W = 12
) (
  input wire core_clk,
  input wire rst_b,
  input wire ctl_cs_b,
  input wire ctl_sclk,
  input wire ctl_sdi,
  output reg ctl_sdo,
  output reg ctl_sdo_oe,
  input wire pcm_fs,
  input wire pcm_bclk,
  input wire pcm_dr,
  output reg pcm_dx,
  output reg pcm_dx_oe,
  input wire [7:0] tx_enc_data,
  output wire rx_word_valid,
  input wire rx_word_ready,
  output wire [7:0] rx_word_data,
  output reg [1:0] tx_input_select,
  output reg sidetone_on,
  output reg earpiece_output_on,
  output reg aux_output_on,
  output reg tone_route_select,
  output reg rx_speech_steer,
  output reg [3:0] tx_gain_code,
  output reg [3:0] sidetone_atten_code,
  output reg [3:0] earpiece_gain_code,
  output reg [3:0] aux_gain_code,
  output reg [3:0] tone_atten_code,
  output reg tone_to_tx_path,
  output reg [TONE_W-1:0] tone_sample
);
  reg rst_s1;
  reg rst_core_b;
  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_s1 <= 1'b0;
      rst_core_b <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rst_core_b <= rst_s1;
    end
  end

  // Pins: cs_b, sclk, sdi, fs, bclk, dr
  wire [5:0] pin_raw = {ctl_cs_b, ctl_sclk, ctl_sdi, pcm_fs, pcm_bclk, pcm_dr};
  reg [5:0] pin_s1;
  reg [5:0] pin_s2;
  reg [5:0] pin_d;
  always @(posedge core_clk or negedge rst_core_b)
  begin
    if (!rst_core_b)
    begin
      pin_s1 <= `CPTC_PIN_IDLE;
      pin_s2 <= `CPTC_PIN_IDLE;
      pin_d <= `CPTC_PIN_IDLE;
    end
    else
    begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_d <= pin_s2;
    end
  end
  wire cs_act = ~pin_s2[5];
  wire sclk_rise = pin_s2[4] & ~pin_d[4];
  wire sclk_fall = ~pin_s2[4] & pin_d[4];
  wire sdi_s = pin_s2[3];
  wire fs_rise = pin_s2[2] & ~pin_d[2];
  wire bclk_rise = pin_s2[1] & ~pin_d[1];
  wire bclk_fall = ~pin_s2[1] & pin_d[1];
  wire dr_s = pin_s2[0];

  reg [7:0] pcm_interface_control;
  reg [7:0] rx_channel_data;
  reg [7:0] tx_channel_data;
  reg [7:0] path_routing_control;
  reg [7:0] tx_and_sidetone_gain;
  reg [7:0] receive_output_gain;
  reg [7:0] tone_generator_control;
  reg [7:0] primary_tone_frequency;
  reg [7:0] secondary_tone_frequency;
  reg [7:0] tone_range_control;

  wire rx_channel_override = pcm_interface_control[`CPTC_RX_OVR];
  wire tx_channel_override = pcm_interface_control[`CPTC_TX_OVR];
  wire voice_en = pcm_interface_control[`CPTC_VOICE_EN];
  wire channel_slot_pick = pcm_interface_control[`CPTC_SLOT_PICK];

  // Serial control port: instruction byte then data byte
  reg [4:0] ctl_cnt;
  reg [7:0] ctl_ins;
  reg [7:0] ctl_shift;
  reg [7:0] ctl_rd_shift;
  reg ctl_wr_stb;
  reg [7:0] ctl_wr_data;
  reg [7:0] read_mux;
  wire [3:0] ctl_addr = ctl_ins[`CPTC_INS_ADDR_HI:0];
  wire [7:0] next_ins = {ctl_shift[6:0], sdi_s};

  always @*
  begin
    case (next_ins[`CPTC_INS_ADDR_HI:0])
      `CPTC_ADDR_PCM_CTRL: read_mux = pcm_interface_control;
      `CPTC_ADDR_RX_DATA: read_mux = rx_channel_data;
      `CPTC_ADDR_ROUTING: read_mux = path_routing_control;
      `CPTC_ADDR_TX_ST_GAIN: read_mux = tx_and_sidetone_gain;
      `CPTC_ADDR_OUT_GAIN: read_mux = receive_output_gain;
      `CPTC_ADDR_TONE_CTRL: read_mux = tone_generator_control;
      `CPTC_ADDR_TONE_PRI: read_mux = primary_tone_frequency;
      `CPTC_ADDR_TONE_SEC: read_mux = secondary_tone_frequency;
      `CPTC_ADDR_TONE_RANGE: read_mux = tone_range_control;
      default: read_mux = `CPTC_RST_BYTE;
    endcase
  end

  always @(posedge core_clk or negedge rst_core_b)
  begin
    if (!rst_core_b)
    begin
      ctl_cnt <= 5'h00;
      ctl_ins <= `CPTC_RST_BYTE;
      ctl_shift <= `CPTC_RST_BYTE;
      ctl_rd_shift <= `CPTC_RST_BYTE;
      ctl_wr_stb <= 1'b0;
      ctl_wr_data <= `CPTC_RST_BYTE;
      ctl_sdo <= 1'b0;
      ctl_sdo_oe <= 1'b0;
    end
    else
    begin
      ctl_wr_stb <= 1'b0;
      if (!cs_act)
      begin
        ctl_cnt <= 5'h00;
        ctl_sdo_oe <= 1'b0;
      end
      else
      begin
        if (sclk_rise && ctl_cnt != `CPTC_FRAME_BITS)
        begin
          ctl_shift <= next_ins;
          ctl_cnt <= ctl_cnt + 5'h01;
          if (ctl_cnt == `CPTC_BYTE_BITS - 5'h01)
          begin
            ctl_ins <= next_ins;
            ctl_rd_shift <= read_mux;
          end
          if (ctl_cnt == `CPTC_FRAME_BITS - 5'h01 && !ctl_ins[`CPTC_INS_READ])
          begin
            ctl_wr_stb <= 1'b1;
            ctl_wr_data <= next_ins;
          end
        end
        // Read data leaves on falling edges, MSB first
        if (sclk_fall && ctl_ins[`CPTC_INS_READ] && ctl_cnt >= `CPTC_BYTE_BITS &&
            ctl_cnt < `CPTC_FRAME_BITS)
        begin
          ctl_sdo <= ctl_rd_shift[7];
          ctl_rd_shift <= {ctl_rd_shift[6:0], 1'b0};
          ctl_sdo_oe <= 1'b1;
        end
        else if (ctl_cnt == `CPTC_FRAME_BITS && sclk_fall)
          ctl_sdo_oe <= 1'b0;
      end
    end
  end

  // PCM framing: bits counted from frame sync
  reg [4:0] pcm_cnt;
  reg [7:0] rx_shift;
  reg [7:0] tx_shift;
  reg rx_pend;
  reg [7:0] rx_pend_data;
  reg rx_capture;
  reg [7:0] rx_capture_data;
  wire [4:0] slot_start = channel_slot_pick ? `CPTC_SLOT2_START : `CPTC_SLOT1_START;
  wire in_slot = (pcm_cnt >= slot_start) && (pcm_cnt < slot_start + `CPTC_SLOT_BITS);
  wire slot_last = (pcm_cnt == slot_start + `CPTC_SLOT_BITS - 5'h01);
  wire buf_in_ready;

  always @(posedge core_clk or negedge rst_core_b)
  begin
    if (!rst_core_b)
    begin
      pcm_cnt <= `CPTC_SLOT_CNT_MAX;
      rx_shift <= `CPTC_RST_BYTE;
      tx_shift <= `CPTC_RST_BYTE;
      rx_capture <= 1'b0;
      rx_capture_data <= `CPTC_RST_BYTE;
      pcm_dx <= 1'b0;
      pcm_dx_oe <= 1'b0;
    end
    else
    begin
      rx_capture <= 1'b0;
      if (fs_rise)
        pcm_cnt <= 5'h00;
      if (bclk_rise && !fs_rise)
      begin
        if (in_slot)
          rx_shift <= {rx_shift[6:0], dr_s};
        if (in_slot && slot_last)
        begin
          rx_capture <= 1'b1;
          rx_capture_data <= {rx_shift[6:0], dr_s};
          // Let go after the last bit is sampled; a parked bit clock gives no further fall
          pcm_dx_oe <= 1'b0;
        end
        if (pcm_cnt != `CPTC_SLOT_CNT_MAX)
          pcm_cnt <= pcm_cnt + 5'h01;
      end
      if (bclk_fall)
      begin
        if (in_slot && voice_en)
        begin
          if (pcm_cnt == slot_start)
          begin
            pcm_dx <= tx_channel_override ? tx_channel_data[7] : tx_enc_data[7];
            tx_shift <= tx_channel_override ? {tx_channel_data[6:0], 1'b0} : {tx_enc_data[6:0], 1'b0};
          end
          else
          begin
            pcm_dx <= tx_shift[7];
            tx_shift <= {tx_shift[6:0], 1'b0};
          end
          pcm_dx_oe <= 1'b1;
        end
        else
          pcm_dx_oe <= 1'b0;
      end
    end
  end

  // Words wait here while the two-entry buffer is full; a newer frame overwrites
  always @(posedge core_clk or negedge rst_core_b)
  begin
    if (!rst_core_b)
    begin
      rx_pend <= 1'b0;
      rx_pend_data <= `CPTC_RST_BYTE;
    end
    else if (rx_capture && voice_en)
    begin
      rx_pend <= 1'b1;
      rx_pend_data <= rx_channel_override ? rx_channel_data : rx_capture_data;
    end
    else if (buf_in_ready)
      rx_pend <= 1'b0;
  end

  cptc_buf2 #(
    .WIDTH(8)
  ) u_rx_buf (
    .clk(core_clk),
    .rst_b(rst_core_b),
    .in_valid(rx_pend),
    .in_ready(buf_in_ready),
    .in_data(rx_pend_data),
    .out_valid(rx_word_valid),
    .out_ready(rx_word_ready),
    .out_data(rx_word_data)
  );

  // Register writes; PCM capture refreshes the receive byte unless overridden
  always @(posedge core_clk or negedge rst_core_b)
  begin
    if (!rst_core_b)
    begin
      pcm_interface_control <= `CPTC_RST_BYTE;
      rx_channel_data <= `CPTC_RST_BYTE;
      tx_channel_data <= `CPTC_RST_BYTE;
      path_routing_control <= `CPTC_RST_BYTE;
      tx_and_sidetone_gain <= `CPTC_RST_BYTE;
      receive_output_gain <= `CPTC_RST_BYTE;
      tone_generator_control <= `CPTC_RST_BYTE;
      primary_tone_frequency <= `CPTC_RST_BYTE;
      secondary_tone_frequency <= `CPTC_RST_BYTE;
      tone_range_control <= `CPTC_RST_BYTE;
    end
    else
    begin
      if (rx_capture && !rx_channel_override)
        rx_channel_data <= rx_capture_data;
      if (ctl_wr_stb)
      begin
        case (ctl_addr)
          `CPTC_ADDR_PCM_CTRL: pcm_interface_control <= ctl_wr_data;
          `CPTC_ADDR_RX_DATA: rx_channel_data <= ctl_wr_data;
          `CPTC_ADDR_TX_DATA: tx_channel_data <= ctl_wr_data;
          `CPTC_ADDR_ROUTING: path_routing_control <= ctl_wr_data;
          `CPTC_ADDR_TX_ST_GAIN: tx_and_sidetone_gain <= ctl_wr_data;
          `CPTC_ADDR_OUT_GAIN: receive_output_gain <= ctl_wr_data;
          `CPTC_ADDR_TONE_CTRL: tone_generator_control <= ctl_wr_data;
          `CPTC_ADDR_TONE_PRI: primary_tone_frequency <= ctl_wr_data;
          `CPTC_ADDR_TONE_SEC: secondary_tone_frequency <= ctl_wr_data;
          `CPTC_ADDR_TONE_RANGE: tone_range_control <= ctl_wr_data;
          default: ;
        endcase
      end
    end
  end

  // Analogue path controls
  wire [1:0] mic_sel = path_routing_control[`CPTC_MIC_HI:`CPTC_MIC_LO];
  wire tx_path_on = voice_en && (mic_sel != `CPTC_MIC_MUTE);
  always @(posedge core_clk or negedge rst_core_b)
  begin
    if (!rst_core_b)
    begin
      tx_input_select <= `CPTC_MIC_MUTE;
      sidetone_on <= 1'b0;
      earpiece_output_on <= 1'b0;
      aux_output_on <= 1'b0;
      tone_route_select <= 1'b0;
      rx_speech_steer <= 1'b0;
      tx_gain_code <= 4'h0;
      sidetone_atten_code <= 4'h0;
      earpiece_gain_code <= 4'h0;
      aux_gain_code <= 4'h0;
      tone_atten_code <= 4'h0;
      tone_to_tx_path <= 1'b0;
    end
    else
    begin
      tx_input_select <= mic_sel;
      sidetone_on <= path_routing_control[`CPTC_SIDETONE_EN] && tx_path_on;
      // Both set is illegal; earpiece wins so the outputs never fight
      earpiece_output_on <= path_routing_control[`CPTC_EARPIECE_ON];
      aux_output_on <= path_routing_control[`CPTC_AUX_ON] && !path_routing_control[`CPTC_EARPIECE_ON];
      tone_route_select <= path_routing_control[`CPTC_TONE_ROUTE];
      rx_speech_steer <= path_routing_control[`CPTC_SPEECH_STEER];
      tx_gain_code <= tx_and_sidetone_gain[7:4];
      sidetone_atten_code <= tx_and_sidetone_gain[3:0];
      earpiece_gain_code <= receive_output_gain[7:4];
      aux_gain_code <= receive_output_gain[3:0];
      tone_atten_code <= tone_generator_control[7:4];
      tone_to_tx_path <= tone_generator_control[`CPTC_TONE_TX];
    end
  end

  // Tone generator: 12-bit phase at the tone rate, step 4w gives w/0.128 Hz
  function [10:0] cptc_sine_mag;
    input [3:0] idx;
    begin
      case (idx)
        4'h0: cptc_sine_mag = 11'd50;
        4'h1: cptc_sine_mag = 11'd150;
        4'h2: cptc_sine_mag = 11'd249;
        4'h3: cptc_sine_mag = 11'd345;
        4'h4: cptc_sine_mag = 11'd438;
        4'h5: cptc_sine_mag = 11'd526;
        4'h6: cptc_sine_mag = 11'd609;
        4'h7: cptc_sine_mag = 11'd687;
        4'h8: cptc_sine_mag = 11'd758;
        4'h9: cptc_sine_mag = 11'd822;
        4'ha: cptc_sine_mag = 11'd878;
        4'hb: cptc_sine_mag = 11'd925;
        4'hc: cptc_sine_mag = 11'd964;
        4'hd: cptc_sine_mag = 11'd993;
        4'he: cptc_sine_mag = 11'd1012;
        default: cptc_sine_mag = 11'd1022;
      endcase
    end
  endfunction

  function [11:0] cptc_wave;
    input [11:0] phase;
    input sine;
    reg [10:0] mag;
    begin
      mag = `CPTC_TONE_FULL;
      if (sine)
        mag = cptc_sine_mag(phase[10] ? ~phase[9:6] : phase[9:6]);
      cptc_wave = phase[11] ? (12'h000 - {1'b0, mag}) : {1'b0, mag};
    end
  endfunction

  reg [31:0] tick_cnt;
  reg tone_tick;
  reg [11:0] pri_phase;
  reg [11:0] sec_phase;
  reg [11:0] pri_step;
  reg [11:0] sec_step;
  always @*
  begin
    case (tone_range_control[1:0])
      `CPTC_RANGE_HALF:
      begin
        pri_step = {3'h0, primary_tone_frequency, 1'b0};
        sec_step = {3'h0, secondary_tone_frequency, 1'b0};
      end
      `CPTC_RANGE_DOUBLE:
      begin
        pri_step = {1'b0, primary_tone_frequency, 3'h0};
        sec_step = {1'b0, secondary_tone_frequency, 3'h0};
      end
      default:
      begin
        pri_step = {2'h0, primary_tone_frequency, 2'h0};
        sec_step = {2'h0, secondary_tone_frequency, 2'h0};
      end
    endcase
  end

  wire pri_on = tone_generator_control[`CPTC_PRI_ON];
  wire sec_on = tone_generator_control[`CPTC_SEC_ON];
  wire sine_sel = tone_generator_control[`CPTC_WAVE];
  wire [11:0] pri_wave = cptc_wave(pri_phase, sine_sel);
  wire [11:0] sec_wave = cptc_wave(sec_phase, sine_sel);
  wire [19:0] sec_prod = {{8{sec_wave[11]}}, sec_wave} * {12'h000, `CPTC_SEC_SCALE};
  wire [11:0] sec_scaled = sec_prod[19:8];
  reg [11:0] next_tone;
  always @*
  begin
    case ({pri_on, sec_on})
      2'b01: next_tone = sec_wave;
      2'b10: next_tone = pri_wave;
      2'b11: next_tone = pri_wave + sec_scaled;
      default: next_tone = 12'h000;
    endcase
  end

  always @(posedge core_clk or negedge rst_core_b)
  begin
    if (!rst_core_b)
    begin
      tick_cnt <= 32'h0;
      tone_tick <= 1'b0;
      pri_phase <= 12'h000;
      sec_phase <= 12'h000;
      tone_sample <= {TONE_W{1'b0}};
    end
    else
    begin
      tone_tick <= 1'b0;
      if (tick_cnt >= TONE_TICK_CYCLES - 1)
      begin
        tick_cnt <= 32'h0;
        tone_tick <= 1'b1;
      end
      else
        tick_cnt <= tick_cnt + 32'h1;
      if (tone_tick)
      begin
        pri_phase <= pri_on ? pri_phase + pri_step : 12'h000;
        sec_phase <= sec_on ? sec_phase + sec_step : 12'h000;
        tone_sample <= next_tone[TONE_W-1:0];
      end
    end
  end
endmodule // cptc_top

/* File: tb/cptc_properties.sv */
`timescale 1ns/1ps
module cptc_properties #(
  parameter TONE_W = 12
) (
  input wire core_clk,
  input wire rst_b,
  input wire ctl_cs_b,
  input wire ctl_sclk,
  input wire ctl_sdo,
  input wire ctl_sdo_oe,
  input wire pcm_bclk,
  input wire pcm_dx,
  input wire pcm_dx_oe,
  input wire rx_word_valid,
  input wire rx_word_ready,
  input wire [7:0] rx_word_data,
  input wire [1:0] tx_input_select,
  input wire sidetone_on,
  input wire earpiece_output_on,
  input wire aux_output_on,
  input wire [TONE_W-1:0] tone_sample
);
  reg bclk_q;
  reg [3:0] dx_falls;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // Counts raw pin falls; the design sees them a few clocks late, so 8 is the ceiling
  always @(posedge core_clk or negedge rst_b)
    if (!rst_b)
    begin
      bclk_q <= 1'b1;
      dx_falls <= 4'h0;
    end
    else
    begin
      bclk_q <= pcm_bclk;
      if (!pcm_dx_oe)
        dx_falls <= 4'h0;
      else if (bclk_q && !pcm_bclk)
        dx_falls <= dx_falls + 4'h1;
    end
  a_sidetone_gated: assert property (sidetone_on |-> tx_input_select != 2'h3)
    else $error("sidetone on while input muted");
  a_outputs_exclusive: assert property (!(earpiece_output_on && aux_output_on))
    else $error("both outputs on");
  a_dx_span: assert property (dx_falls <= 4'h8)
    else $error("transmit slot longer than eight bits");
  a_dx_on_low: assert property (pcm_dx_oe && $changed(pcm_dx) |-> !pcm_bclk)
    else $error("transmit bit changed while bit clock high");
  a_rx_word_hold: assert property (rx_word_valid && !rx_word_ready |=> rx_word_valid && $stable(rx_word_data))
    else $error("stalled word lost");
  a_sdo_selected: assert property ($rose(ctl_sdo_oe) |-> !ctl_cs_b)
    else $error("read data driven while deselected");
  a_sdo_on_low: assert property (ctl_sdo_oe && $changed(ctl_sdo) |-> !ctl_sclk)
    else $error("read bit changed while serial clock high");
  a_sdo_release: assert property (ctl_cs_b [*5] |-> !ctl_sdo_oe)
    else $error("read data still driven after deselect");
  a_tone_hold: assert property ($changed(tone_sample) |=> $stable(tone_sample) [*8])
    else $error("tone sample changed between ticks");
  c_rx_stall: cover property (rx_word_valid && !rx_word_ready ##1 rx_word_ready);
  c_read: cover property ($rose(ctl_sdo_oe));
  c_dx: cover property ($rose(pcm_dx_oe));
endmodule // cptc_properties

bind cptc_top cptc_properties #(.TONE_W(TONE_W)) i_props (.core_clk(core_clk), .rst_b(rst_b),
  .ctl_cs_b(ctl_cs_b), .ctl_sclk(ctl_sclk), .ctl_sdo(ctl_sdo), .ctl_sdo_oe(ctl_sdo_oe),
  .pcm_bclk(pcm_bclk), .pcm_dx(pcm_dx), .pcm_dx_oe(pcm_dx_oe), .rx_word_valid(rx_word_valid),
  .rx_word_ready(rx_word_ready), .rx_word_data(rx_word_data), .tx_input_select(tx_input_select),
  .sidetone_on(sidetone_on), .earpiece_output_on(earpiece_output_on), .aux_output_on(aux_output_on),
  .tone_sample(tone_sample));

/* File: tb/cptc_pcm_dsp.sv */
`timescale 1ns/1ps
module cptc_pcm_dsp (
  input wire core_clk,
  input wire pcm_dx,
  input wire pcm_dx_oe,
  output reg pcm_fs,
  output reg pcm_bclk,
  output reg pcm_dr
);
  reg [15:0] dx_seen;
  reg [15:0] oe_seen;
  integer k;
  initial
  begin
    pcm_fs = 1'b0;
    pcm_bclk = 1'b1;
    pcm_dr = 1'b0;
  end
  // Bit clock parked high between frames; bit 15 is the first bit of the frame
  task frame(input [15:0] bits);
    begin
      pcm_fs = 1'b1;
      repeat (6) @(negedge core_clk);
      for (k = 15; k >= 0; k = k - 1)
      begin
        pcm_bclk = 1'b0;
        pcm_dr = bits[k];
        repeat (6) @(negedge core_clk);
        dx_seen[k] = pcm_dx;
        oe_seen[k] = pcm_dx_oe;
        pcm_bclk = 1'b1;
        pcm_fs = 1'b0;
        repeat (6) @(negedge core_clk);
      end
      // Released line must not keep showing the last bit
      pcm_dr = ~pcm_dr;
      repeat (6) @(negedge core_clk);
    end
  endtask
endmodule // cptc_pcm_dsp

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  localparam TICK = 20;
  reg core_clk, rst_b, ctl_cs_b, ctl_sclk, ctl_sdi, rx_word_ready, ns;
  reg [7:0] tx_enc_data, v;
  reg [31:0] hp;
  wire ctl_sdo, ctl_sdo_oe, pcm_fs, pcm_bclk, pcm_dr, pcm_dx, pcm_dx_oe, rx_word_valid;
  wire sidetone_on, earpiece_output_on, aux_output_on, tone_route_select, rx_speech_steer, tone_to_tx_path;
  wire [7:0] rx_word_data;
  wire [1:0] tx_input_select;
  wire [3:0] tx_gain_code, sidetone_atten_code, earpiece_gain_code, aux_gain_code, tone_atten_code;
  wire [11:0] tone_sample;
  integer errors, cmp_count, i, c;
  cptc_top #(.TONE_TICK_CYCLES(TICK)) i_dut (.core_clk(core_clk), .rst_b(rst_b),
    .ctl_cs_b(ctl_cs_b), .ctl_sclk(ctl_sclk), .ctl_sdi(ctl_sdi), .ctl_sdo(ctl_sdo), .ctl_sdo_oe(ctl_sdo_oe),
    .pcm_fs(pcm_fs), .pcm_bclk(pcm_bclk), .pcm_dr(pcm_dr), .pcm_dx(pcm_dx), .pcm_dx_oe(pcm_dx_oe),
    .tx_enc_data(tx_enc_data), .rx_word_valid(rx_word_valid), .rx_word_ready(rx_word_ready),
    .rx_word_data(rx_word_data), .tx_input_select(tx_input_select), .sidetone_on(sidetone_on),
    .earpiece_output_on(earpiece_output_on), .aux_output_on(aux_output_on),
    .tone_route_select(tone_route_select), .rx_speech_steer(rx_speech_steer), .tx_gain_code(tx_gain_code),
    .sidetone_atten_code(sidetone_atten_code), .earpiece_gain_code(earpiece_gain_code),
    .aux_gain_code(aux_gain_code), .tone_atten_code(tone_atten_code), .tone_to_tx_path(tone_to_tx_path),
    .tone_sample(tone_sample));
  cptc_pcm_dsp i_dsp (.core_clk(core_clk), .pcm_dx(pcm_dx), .pcm_dx_oe(pcm_dx_oe), .pcm_fs(pcm_fs),
    .pcm_bclk(pcm_bclk), .pcm_dr(pcm_dr));
  always #2.5 core_clk = ~core_clk;
  task chk(input [23:0] seen, input [23:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp)
      begin
        errors = errors + 1;
        $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task end_of_test;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  // Serial clock phases of 5 clocks clear the 2FF synchroniser margin
  task ctl(input [7:0] ins, input [7:0] wd);
    integer k;
    reg [15:0] sh;
    begin
      sh = {ins, wd};
      ctl_cs_b = 1'b0;
      for (k = 15; k >= 0; k = k - 1)
      begin
        ctl_sclk = 1'b0;
        ctl_sdi = sh[k];
        repeat (5) @(negedge core_clk);
        if (k < 8)
          v[k] = ctl_sdo;
        ctl_sclk = 1'b1;
        repeat (5) @(negedge core_clk);
      end
      repeat (4) @(negedge core_clk);
      ctl_cs_b = 1'b1;
      repeat (8) @(negedge core_clk);
    end
  endtask
  task wr(input [3:0] a, input [7:0] d);
    ctl({4'h0, a}, d);
  endtask
  task rdc(input [3:0] a, input [7:0] e);
    begin
      ctl({4'h8, a}, 8'h00);
      chk(v, e);
    end
  endtask
  task pop(input [7:0] e);
    begin
      c = 0;
      while (rx_word_valid !== 1'b1 && c < 50)
      begin
        @(negedge core_clk);
        c = c + 1;
      end
      chk({rx_word_valid, rx_word_data}, {1'b1, e});
      rx_word_ready = 1'b1;
      @(negedge core_clk);
      rx_word_ready = 1'b0;
      @(negedge core_clk);
    end
  endtask
  task flip;
    begin
      ns = tone_sample[11];
      c = 0;
      while (tone_sample[11] === ns && c < 3000)
      begin
        @(negedge core_clk);
        c = c + 1;
      end
    end
  endtask
  initial
  begin
    #400000;
    errors = errors + 1;
    end_of_test;
  end
  initial
  begin
    errors = 0;
    cmp_count = 0;
    core_clk = 1'b0;
    rst_b = 1'b0;
    ctl_cs_b = 1'b1;
    ctl_sclk = 1'b1;
    ctl_sdi = 1'b0;
    rx_word_ready = 1'b0;
    tx_enc_data = 8'ha5;
    hp = {8'd8, 8'd16, 8'd4, 8'd16};
    repeat (3) @(negedge core_clk);
    rst_b = 1'b1;
    repeat (6) @(negedge core_clk);
    for (i = 0; i < 12; i = i + 1)
      rdc(i[3:0], 8'h00);
    chk(tx_input_select, 2'h0);
    $display("test reset_values done");
    wr(4'h5, 8'ha3);
    wr(4'h6, 8'h7c);
    wr(4'h7, 8'hc1);
    wr(4'h4, 8'h55);
    wr(4'h3, 8'h96);
    wr(4'hb, 8'hff);
    rdc(4'h5, 8'ha3);
    rdc(4'h6, 8'h7c);
    rdc(4'h7, 8'hc1);
    rdc(4'h3, 8'h00);
    rdc(4'hb, 8'h00);
    chk({tx_gain_code, sidetone_atten_code, earpiece_gain_code, aux_gain_code}, 16'ha37c);
    chk({tone_atten_code, tone_to_tx_path}, 5'h19);
    chk({tx_input_select, sidetone_on, earpiece_output_on, aux_output_on, tone_route_select, rx_speech_steer}, 7'h2b);
    wr(4'h4, 8'h8a);
    chk({tx_input_select, sidetone_on, earpiece_output_on, aux_output_on, tone_route_select, rx_speech_steer}, 7'h44);
    wr(4'h1, 8'h04);
    for (i = 3; i >= 0; i = i - 1)
    begin
      wr(4'h4, {i[1:0], 6'h20});
      chk({tx_input_select, sidetone_on}, {i[1:0], i != 3});
    end
    wr(4'h1, 8'h00);
    chk(sidetone_on, 1'b0);
    $display("test routing done");
    wr(4'h1, 8'h04);
    i_dsp.frame(16'h3cc3);
    chk({i_dsp.dx_seen[15:8], i_dsp.oe_seen}, 24'ha5ff00);
    rdc(4'h2, 8'h3c);
    i_dsp.frame(16'h8100);
    i_dsp.frame(16'h7e00);
    pop(8'h3c);
    pop(8'h81);
    pop(8'h7e);
    chk(rx_word_valid, 1'b0);
    wr(4'h1, 8'h00);
    i_dsp.frame(16'h1234);
    chk({i_dsp.oe_seen, rx_word_valid}, 17'h0);
    $display("test pcm_slot1 done");
    wr(4'h2, 8'h5a);
    wr(4'h3, 8'h96);
    wr(4'h1, 8'h1e);
    i_dsp.frame(16'h1122);
    chk({i_dsp.dx_seen[7:0], i_dsp.oe_seen}, 24'h9600ff);
    pop(8'h5a);
    rdc(4'h2, 8'h5a);
    wr(4'h1, 8'h06);
    tx_enc_data = 8'h3c;
    i_dsp.frame(16'h1166);
    chk({i_dsp.dx_seen[7:0], i_dsp.oe_seen}, 24'h3c00ff);
    pop(8'h66);
    rdc(4'h2, 8'h66);
    $display("test pcm_override done");
    wr(4'h8, 8'h40);
    wr(4'h9, 8'h20);
    for (i = 0; i < 4; i = i + 1)
    begin
      wr(4'ha, (i == 3) ? 8'h00 : i[7:0]);
      wr(4'h7, (i == 3) ? 8'h04 : 8'h08);
      flip;
      flip;
      flip;
      chk(c[23:0], hp[31 - 8 * i -: 8] * TICK);
      chk(tone_sample, tone_sample[11] ? 12'hc01 : 12'h3ff);
    end
    wr(4'h7, 8'h0a);
    ns = 1'b0;
    repeat (8)
    begin
      repeat (TICK) @(negedge core_clk);
      ns = ns | (tone_sample !== 12'h3ff && tone_sample !== 12'hc01);
    end
    chk(ns, 1'b1);
    wr(4'h7, 8'h00);
    repeat (3 * TICK) @(negedge core_clk);
    chk(tone_sample, 12'h000);
    wr(4'h7, 8'h0c);
    repeat (2 * TICK) @(negedge core_clk);
    chk(tone_sample, 12'h72a);
    $display("test tone done");
    end_of_test;
  end
endmodule // tb_top
